//--- adc_ctrl_pkg.sv
// Purpose: Shared constants for the sample packetizer control block.
// Assumes: APB with 32-bit data, one register per aligned word.
// Notes: Offsets are byte addresses.
package adc_ctrl_pkg;
	localparam int NUM_INPUTS = 8;
	localparam int IDX_W = 3;
	localparam int RES_W = 12;
	localparam int ADDR_W = 8;
	// Register byte offsets.
	localparam logic [ADDR_W-1:0] OFF_INPUT0 = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_INPUT7 = 8'h1C;
	localparam logic [ADDR_W-1:0] OFF_GENERAL = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h24;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h28;
	// Per-input register fields.
	localparam int DEST_LSB = 8;
	localparam int DEST_W = 24;
	localparam int INPUT_EN_BIT = 0;
	// General control fields.
	localparam int ENABLE_BIT = 0;
	localparam int CALIB_BIT = 1;
	localparam int PKT_LSB = 8;
	localparam int PKT_W = 8;
	localparam int WIDTH_LSB = 16;
	localparam int DROP_BIT = 24;
	// Reset values.
	localparam logic [PKT_W-1:0] PKT_RESET = 8'h01;
	localparam logic [1:0] WIDTH_RESET = 2'h1;
	// Sample width codes.
	localparam logic [1:0] FMT_8 = 2'h0;
	localparam logic [1:0] FMT_16 = 2'h1;
	localparam logic [1:0] FMT_32 = 2'h3;
	// Calibration pulses after each enable.
	localparam logic [2:0] CAL_PULSES = 3'h6;
	// Interrupt status bits.
	localparam int IRQ_DROP = 0;
	localparam int IRQ_PKT_END = 1;
	localparam int IRQ_W = 2;
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_BYTES = 2'b01,
		TX_END = 2'b10
	} tx_state_t;
endpackage

//--- adc_sample_packetizer_control.sv
// Purpose: Register file, calibration sequencing and sample packetizing for an 8-input converter.
// Assumes: APB slave, zero wait states; conversion results arrive as a one-cycle strobe.
// Notes: Output bytes go one per cycle, with a destination and end-of-packet mark.
// Overview of operation
// - Per-input bits 31:8 hold the 24-bit destination identifier, reset zero.
// - Per-input bit 0 enables that input; bits 7:1 read zero.
// - General bit 24 flags a dropped sample, resets to one, cleared by reads.
// - Width field 17:16 picks 8, 16 or 32 bits, resets to 16; left aligned.
// - Eight-bit format keeps only the upper eight result bits.
// - Sixteen-bit format pads four zero bits, high byte sent first.
// - Thirty-two-bit format pads twenty zero bits, high byte first.
// - Field 15:8 sets samples per packet, resets to one.
// - Zero samples per packet keeps the packet open until an input or general register access.
// - General bit 1 selects the internal calibration reference, resets zero.
// - General bit 0 enables the converter and locks per-input registers.
// - First six trigger pulses after enable calibrate and yield no packets.
// - From the seventh pulse on, each pulse delivers a sample.
// - Calibration restarts on every enable rising edge.
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
module adc_sample_packetizer_control (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic trigger_pin,
	input wire logic result_valid,
	input wire logic [11:0] result_data,
	output logic trigger_out,
	output logic [2:0] input_select,
	output logic calib_select,
	output logic conv_enable,
	output logic [7:0] tx_data,
	output logic [23:0] tx_dest,
	output logic tx_valid,
	output logic tx_end,
	output logic irq
);
	localparam int N = adc_ctrl_pkg::NUM_INPUTS;

	logic [23:0] dest_reg [N];
	logic [N-1:0] in_en_reg;
	logic enable_reg;
	logic calib_reg;
	logic [1:0] width_reg;
	logic [7:0] pkt_len_reg;
	logic drop_reg;
	logic [1:0] irq_status_reg;
	logic [1:0] irq_mask_reg;
	logic trig_s1_reg;
	logic trig_s2_reg;
	logic trig_s3_reg;
	logic [2:0] cal_cnt_reg;
	logic [2:0] cur_in_reg;
	logic [2:0] pend_in_reg;
	logic pend_reg;
	logic [31:0] word_reg;
	logic [1:0] byte_left_reg;
	logic [7:0] sent_cnt_reg;
	logic pkt_open_reg;
	logic [23:0] pkt_dest_reg;
	adc_ctrl_pkg::tx_state_t tx_state_reg;

	logic apb_access;
	logic apb_wr;
	logic apb_rd;
	logic trig_rise;
	logic enable_rise;
	logic ctl_access;
	logic has_input;
	logic [2:0] next_in;
	logic [31:0] rd_next;
	logic drop_event;
	logic pkt_end_event;
	logic [31:0] fmt_word;
	logic [1:0] fmt_bytes;
	logic close_now;
	logic bad_addr;

	assign apb_access = psel && penable;
	assign apb_wr = apb_access && pwrite;
	assign apb_rd = apb_access && !pwrite;
	assign trig_rise = trig_s2_reg && !trig_s3_reg;
	// Accesses to the input or general registers count as control accesses.
	assign ctl_access = apb_access && (paddr <= adc_ctrl_pkg::OFF_GENERAL);
	assign enable_rise = apb_wr && (paddr == adc_ctrl_pkg::OFF_GENERAL) &&
		pwdata[adc_ctrl_pkg::ENABLE_BIT] && !enable_reg;
	assign has_input = |in_en_reg;
	// Unaligned words and anything past the mask register are refused.
	assign bad_addr = paddr[1:0] != 2'h0 || paddr > adc_ctrl_pkg::OFF_IRQ_MASK;

	// Next enabled input after the current one, round robin.
	// The scan runs from the far end down, so the nearest enabled input wins the last write.
	// With no input enabled the choice stays put, which is harmless as nothing is delivered.
	always_comb begin
		next_in = cur_in_reg;
		for (int k = N; k >= 1; k--) begin
			if (in_en_reg[3'(cur_in_reg + 3'(k))]) begin
				next_in = 3'(cur_in_reg + 3'(k));
			end
		end
	end

	// Trigger pin is asynchronous, so it passes two flops before edge detection.
	// The third flop only serves the edge detector; it resets low like the idle pin.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			trig_s1_reg <= 1'b0;
			trig_s2_reg <= 1'b0;
			trig_s3_reg <= 1'b0;
		end else if (clk_en) begin
			trig_s1_reg <= trigger_pin;
			trig_s2_reg <= trig_s1_reg;
			trig_s3_reg <= trig_s2_reg;
		end
	end

	// Per-input registers; writes are ignored while the converter runs.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < N; i++) begin
				dest_reg[i] <= 24'h000000;
			end
			in_en_reg <= '0;
		end else if (clk_en) begin
			if (apb_wr && !enable_reg && paddr <= adc_ctrl_pkg::OFF_INPUT7 &&
				paddr[1:0] == 2'h0) begin
				dest_reg[paddr[4:2]] <= pwdata[adc_ctrl_pkg::DEST_LSB +: adc_ctrl_pkg::DEST_W];
				in_en_reg[paddr[4:2]] <= pwdata[adc_ctrl_pkg::INPUT_EN_BIT];
			end
		end
	end

	// General control fields.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			enable_reg <= 1'b0;
			calib_reg <= 1'b0;
			width_reg <= adc_ctrl_pkg::WIDTH_RESET;
			pkt_len_reg <= adc_ctrl_pkg::PKT_RESET;
		end else if (clk_en) begin
			if (apb_wr && paddr == adc_ctrl_pkg::OFF_GENERAL) begin
				enable_reg <= pwdata[adc_ctrl_pkg::ENABLE_BIT];
				calib_reg <= pwdata[adc_ctrl_pkg::CALIB_BIT];
				width_reg <= pwdata[adc_ctrl_pkg::WIDTH_LSB +: 2];
				pkt_len_reg <= pwdata[adc_ctrl_pkg::PKT_LSB +: adc_ctrl_pkg::PKT_W];
			end
		end
	end

	// Calibration counter counts down the pulses owed after each enable edge.
	// A disable leaves the count alone; the next enable edge reloads it anyway.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cal_cnt_reg <= adc_ctrl_pkg::CAL_PULSES;
		end else if (clk_en) begin
			if (enable_rise) begin
				cal_cnt_reg <= adc_ctrl_pkg::CAL_PULSES;
			end else if (enable_reg && trig_rise && cal_cnt_reg != 3'h0) begin
				cal_cnt_reg <= cal_cnt_reg - 3'h1;
			end
		end
	end

	// Converter drive: every pulse goes on while enabled, only the input choice changes.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			trigger_out <= 1'b0;
			input_select <= 3'h0;
			cur_in_reg <= 3'h0;
			calib_select <= 1'b0;
			conv_enable <= 1'b0;
			pend_in_reg <= 3'h0;
		end else if (clk_en) begin
			calib_select <= calib_reg;
			conv_enable <= enable_reg;
			trigger_out <= enable_reg && trig_rise;
			if (enable_reg && trig_rise) begin
				input_select <= next_in;
				cur_in_reg <= next_in;
				pend_in_reg <= next_in;
			end
		end
	end

	// Format the result left aligned in a 32-bit word with the byte count less one.
	always_comb begin
		fmt_word = {result_data, 20'h00000};
		fmt_bytes = 2'h3;
		unique case (width_reg)
			adc_ctrl_pkg::FMT_8: fmt_bytes = 2'h0;
			adc_ctrl_pkg::FMT_16: fmt_bytes = 2'h1;
			adc_ctrl_pkg::FMT_32: fmt_bytes = 2'h3;
			default: fmt_bytes = 2'h1;
		endcase
	end

	// overrun detection
	// A result landing while the transmitter is busy, in its byte or closing cycle alike,
	// cannot be held because there is no buffer, so it is an overrun.
	assign drop_event = clk_en && result_valid && enable_reg &&
		has_input && tx_state_reg != adc_ctrl_pkg::TX_IDLE;
	assign close_now = pkt_open_reg && pkt_len_reg == 8'h00 && ctl_access;
	assign pkt_end_event = clk_en && tx_valid && tx_end;

	// Packet transmitter: bytes go out one per cycle, top byte first.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_state_reg <= adc_ctrl_pkg::TX_IDLE;
			word_reg <= 32'h00000000;
			byte_left_reg <= 2'h0;
			sent_cnt_reg <= 8'h00;
			pkt_open_reg <= 1'b0;
			pkt_dest_reg <= 24'h000000;
			pend_reg <= 1'b0;
			tx_data <= 8'h00;
			tx_dest <= 24'h000000;
			tx_valid <= 1'b0;
			tx_end <= 1'b0;
		end else if (clk_en) begin
			tx_valid <= 1'b0;
			tx_end <= 1'b0;
			// calibration results suppressed
			// The trigger, not the result, decides: the sixth pulse's result arrives after the
			// counter has reached zero and must still be thrown away.
			if (enable_reg && trig_rise && cal_cnt_reg == 3'h0) begin
				pend_reg <= 1'b1;
			end else if (result_valid || enable_rise) begin
				pend_reg <= 1'b0;
			end
			unique case (tx_state_reg)
				adc_ctrl_pkg::TX_IDLE: begin
					if (result_valid && enable_reg && pend_reg && has_input) begin
						word_reg <= fmt_word;
						byte_left_reg <= fmt_bytes;
						pkt_dest_reg <= dest_reg[pend_in_reg];
						tx_state_reg <= adc_ctrl_pkg::TX_BYTES;
					end else if (close_now) begin
						// Zero-length terminator ends a held-open packet.
						tx_valid <= 1'b1;
						tx_end <= 1'b1;
						tx_data <= 8'h00;
						tx_dest <= pkt_dest_reg;
						pkt_open_reg <= 1'b0;
						sent_cnt_reg <= 8'h00;
					end
				end
				adc_ctrl_pkg::TX_BYTES: begin
					tx_valid <= 1'b1;
					tx_data <= word_reg[31:24];
					tx_dest <= pkt_dest_reg;
					word_reg <= {word_reg[23:0], 8'h00};
					byte_left_reg <= byte_left_reg - 2'h1;
					pkt_open_reg <= 1'b1;
					if (byte_left_reg == 2'h0) begin
						tx_state_reg <= adc_ctrl_pkg::TX_END;
					end
				end
				adc_ctrl_pkg::TX_END: begin
					tx_state_reg <= adc_ctrl_pkg::TX_IDLE;
					if (pkt_len_reg != 8'h00 && sent_cnt_reg + 8'h01 >= pkt_len_reg) begin
						tx_valid <= 1'b1;
						tx_end <= 1'b1;
						tx_data <= 8'h00;
						pkt_open_reg <= 1'b0;
						sent_cnt_reg <= 8'h00;
					end else begin
						sent_cnt_reg <= sent_cnt_reg + 8'h01;
					end
				end
				default: tx_state_reg <= adc_ctrl_pkg::TX_IDLE;
			endcase
		end
	end

	// Dropped flag: set wins over the clear by a read in the same cycle.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			drop_reg <= 1'b1;
		end else if (clk_en) begin
			if (drop_event) begin
				drop_reg <= 1'b1;
			end else if (apb_rd && paddr == adc_ctrl_pkg::OFF_GENERAL) begin
				drop_reg <= 1'b0;
			end
		end
	end

	// Interrupt status is write-one-to-clear; a new event wins.
	// The output is registered, so it lags the status by a cycle but never glitches.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_status_reg <= 2'h0;
			irq_mask_reg <= 2'h0;
			irq <= 1'b0;
		end else if (clk_en) begin
			for (int b = 0; b < adc_ctrl_pkg::IRQ_W; b++) begin
				if ((b == adc_ctrl_pkg::IRQ_DROP && drop_event) ||
					(b == adc_ctrl_pkg::IRQ_PKT_END && pkt_end_event)) begin
					irq_status_reg[b] <= 1'b1;
				end else if (apb_wr && paddr == adc_ctrl_pkg::OFF_IRQ_STATUS && pwdata[b]) begin
					irq_status_reg[b] <= 1'b0;
				end
			end
			if (apb_wr && paddr == adc_ctrl_pkg::OFF_IRQ_MASK) begin
				irq_mask_reg <= pwdata[1:0];
			end
			irq <= |(irq_status_reg & irq_mask_reg);
		end
	end

	// Read mux; reserved bits read zero.
	// Unaligned addresses are zeroed at the answer register, not here.
	always_comb begin
		rd_next = 32'h00000000;
		if (paddr <= adc_ctrl_pkg::OFF_INPUT7) begin
			rd_next = {dest_reg[paddr[4:2]], 7'h00, in_en_reg[paddr[4:2]]};
		end else if (paddr == adc_ctrl_pkg::OFF_GENERAL) begin
			rd_next = {7'h00, drop_reg, 6'h00, width_reg, pkt_len_reg, 6'h00, calib_reg, enable_reg};
		end else if (paddr == adc_ctrl_pkg::OFF_IRQ_STATUS) begin
			rd_next = {30'h00000000, irq_status_reg};
		end else if (paddr == adc_ctrl_pkg::OFF_IRQ_MASK) begin
			rd_next = {30'h00000000, irq_mask_reg};
		end
	end

	// APB answer: ready in the first access cycle, error on unmapped words.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && bad_addr;
			if (psel && !penable) begin
				// A refused read answers zero rather than leaking a neighbouring register.
				prdata <= bad_addr ? 32'h00000000 : rd_next;
			end
		end
	end
endmodule

//--- adc_ctrl_chk.sv
// Purpose: Port assertions for the sample packetizer control block.
// Assumes: clk_en is held high by the bench.
// Notes: Bound to the design module after the checker.
`timescale 1ns/1ps
module adc_ctrl_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic trigger_pin,
	input wire logic trigger_out,
	input wire logic calib_select,
	input wire logic conv_enable,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	input wire logic tx_end
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Steps of a transfer and of a general control write.
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence gen_wr_s;
		psel && penable && pready && pwrite && paddr == 8'h20;
	endsequence
	// The slave answers in the first access cycle, for one cycle only.
	a_ready_after_setup: assert property (setup_s |=> pready)
		else $error("no ready in access cycle");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready held too long");
	// Unmapped places answer with an error and read zero.
	a_err_unmapped: assert property (setup_s ##1 (penable && paddr > 8'h28) |-> pslverr)
		else $error("unmapped access not refused");
	a_err_reads_zero: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
		else $error("refused read not zero");
	a_enable_copy: assert property (gen_wr_s |-> ##2 conv_enable == $past(pwdata[0], 2))
		else $error("enable output not following bit 0");
	a_calib_copy: assert property (gen_wr_s |-> ##2 calib_select == $past(pwdata[1], 2))
		else $error("reference select not following bit 1");
	a_trig_latency: assert property ($rose(trigger_pin) && conv_enable |-> ##[1:4] trigger_out)
		else $error("trigger not passed on");
	// end token is a zero byte.
	a_end_token: assert property (tx_end |-> tx_valid && tx_data == 8'h00)
		else $error("bad end token");
endmodule
bind adc_sample_packetizer_control adc_ctrl_chk chk_inst (.clk(clk), .rst_n(rst_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .trigger_pin(trigger_pin),
	.trigger_out(trigger_out), .calib_select(calib_select), .conv_enable(conv_enable),
	.tx_data(tx_data), .tx_valid(tx_valid), .tx_end(tx_end));

//--- far_side_model.sv
// Purpose: Converter and receiving channel-end beside the block.
// Assumes: One result per trigger, two when double_hit is set.
// Notes: Result lines show the inverse of the last value when idle.
`timescale 1ns/1ps
module far_side_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic trigger_out,
	input wire logic double_hit,
	input wire logic [11:0] res_value,
	output logic result_valid,
	output logic [11:0] result_data,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	input wire logic tx_end
);
	logic [1:0] pend;
	logic [7:0] rx_q[$];
	int ends;
	// Converter answers each trigger; a second result forces a drop.
	// The first result of a burst carries res_value, a second one its inverse.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pend <= 2'h0;
			result_valid <= 1'b0;
			result_data <= 12'hFFF;
		end else begin
			result_valid <= pend != 2'h0;
			result_data <= (pend != 2'h0 && !result_valid) ? res_value : ~result_data;
			if (trigger_out)
				pend <= double_hit ? 2'h2 : 2'h1;
			else if (pend != 2'h0)
				pend <= pend - 2'h1;
		end
	end
	// Channel-end keeps data bytes in order and counts end tokens.
	always @(posedge clk) begin
		if (tx_valid && !tx_end)
			rx_q.push_back(tx_data);
		if (tx_valid && tx_end)
			ends++;
	end
endmodule

//--- tb.sv
// Purpose: Self-checking bench for the sample packetizer control block.
// Assumes: Zero-wait APB answers, bench timeout guards every wait.
// Notes: Random results and destinations come from a fixed seed.
`timescale 1ns/1ps
module tb;
	logic clk, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err, double_hit = 0;
	logic trigger_pin = 0, result_valid, trigger_out, tx_valid, tx_end, irq;
	logic [7:0] paddr = 8'h00, tx_data;
	logic [31:0] pwdata = 32'h0, prdata, rd, w;
	logic pready, pslverr;
	logic [11:0] result_data, res_value = 12'h000;
	logic [23:0] dest, tx_dest;
	logic [1:0] f;
	logic [2:0] isel;
	int failures = 0, comparisons = 0, cycles = 0;
	adc_sample_packetizer_control adc_sample_packetizer_control_inst (.clk(clk), .rst_n(rst_n),
		.clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.trigger_pin(trigger_pin), .result_valid(result_valid), .result_data(result_data),
		.trigger_out(trigger_out), .input_select(isel), .calib_select(), .conv_enable(),
		.tx_data(tx_data), .tx_dest(tx_dest), .tx_valid(tx_valid), .tx_end(tx_end), .irq(irq));
	far_side_model far_side_model_inst (.clk(clk), .rst_n(rst_n), .trigger_out(trigger_out),
		.double_hit(double_hit), .res_value(res_value), .result_valid(result_valid),
		.result_data(result_data), .tx_data(tx_data), .tx_valid(tx_valid), .tx_end(tx_end));
	// Free-running clock.
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	// Hang guard, well above the length of the run.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("Counts: %0d comparisons, %0d failures", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	// One APB transfer; request held until ready is sampled high.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic pulse(input int n);
		repeat (n) begin
			trigger_pin <= 1'b1;
			repeat (4) @(posedge clk);
			trigger_pin <= 1'b0;
			repeat (20) @(posedge clk);
		end
	endtask
	// Left-aligned sample word for a width code.
	function automatic logic [31:0] exp_word(input logic [1:0] c, input logic [11:0] r);
		if (c == adc_ctrl_pkg::FMT_8)
			return {24'h0, r[11:4]};
		if (c == adc_ctrl_pkg::FMT_16)
			return {16'h0, r, 4'h0};
		return {r, 20'h0};
	endfunction
	// Gathers the received bytes, first byte most significant.
	task automatic check_sample(input int n);
		w = 32'h0;
		foreach (far_side_model_inst.rx_q[i])
			w = {w[23:0], far_side_model_inst.rx_q[i]};
		check(32'(far_side_model_inst.rx_q.size()), 32'(n));
		check(w, exp_word(f, res_value));
		check({8'h0, tx_dest}, {8'h0, dest});
		check({29'h0, isel}, 32'h7);
		far_side_model_inst.rx_q.delete();
	endtask
	initial begin
		void'($urandom(8870));
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		apb(0, adc_ctrl_pkg::OFF_GENERAL, 0);
		check(rd, 32'h0101_0100);
		apb(0, adc_ctrl_pkg::OFF_GENERAL, 0);
		check(rd, 32'h0001_0100);
		apb(0, adc_ctrl_pkg::OFF_INPUT7, 0);
		check(rd, 32'h0);
		dest = $urandom;
		apb(1, adc_ctrl_pkg::OFF_INPUT7, {dest, 8'hFF});
		apb(0, adc_ctrl_pkg::OFF_INPUT7, 0);
		check(rd, {dest, 8'h01});
		$display("Test registers done");
		for (int k = 0; k < 3; k++) begin
			f = (k == 2) ? adc_ctrl_pkg::FMT_32 : 2'(k);
			apb(1, adc_ctrl_pkg::OFF_GENERAL, {14'h0, f, 16'h0100});
			apb(1, adc_ctrl_pkg::OFF_GENERAL, {14'h0, f, 14'h0040, k == 1, 1'b1});
			far_side_model_inst.rx_q.delete();
			far_side_model_inst.ends = 0;
			pulse(6);
			check(32'(far_side_model_inst.rx_q.size()), 32'h0);
			// one sample discarded after entering the reference.
			if (k == 1) begin
				pulse(1);
				far_side_model_inst.rx_q.delete();
				far_side_model_inst.ends = 0;
			end
			res_value = $urandom;
			pulse(1);
			check_sample((k == 2) ? 4 : k + 1);
			check(32'(far_side_model_inst.ends), 32'h1);
			$display("Test format %0d done", k);
		end
		apb(1, adc_ctrl_pkg::OFF_INPUT7, 32'h0);
		apb(0, adc_ctrl_pkg::OFF_INPUT7, 0);
		check(rd, {dest, 8'h01});
		apb(0, adc_ctrl_pkg::OFF_GENERAL, 0);
		double_hit <= 1'b1;
		res_value = $urandom;
		pulse(1);
		check_sample(4);
		apb(0, adc_ctrl_pkg::OFF_GENERAL, 0);
		check(rd[24], 1'b1);
		double_hit <= 1'b0;
		$display("Test drop done");
		apb(1, adc_ctrl_pkg::OFF_IRQ_MASK, 32'h2);
		repeat (2) @(posedge clk);
		check(irq, 1'b1);
		apb(1, adc_ctrl_pkg::OFF_IRQ_STATUS, 32'h2);
		repeat (2) @(posedge clk);
		check(irq, 1'b0);
		apb(0, 8'h2C, 0);
		check({31'h0, err}, 32'h1);
		check(rd, 32'h0);
		$display("Test interrupt and refusal done");
		apb(1, adc_ctrl_pkg::OFF_GENERAL, 32'h0000_0001);
		far_side_model_inst.ends = 0;
		pulse(2);
		check(32'(far_side_model_inst.ends), 32'h0);
		apb(0, adc_ctrl_pkg::OFF_INPUT0, 0);
		repeat (3) @(posedge clk);
		check(32'(far_side_model_inst.ends), 32'h1);
		$display("Test open packet done");
		print_verdict();
	end
endmodule
